// File: rtl/olb_overlay_layer.sv
// overlay layer: apb registers, fetch address stepping, pixel blender and
// the channel start/stop/abort control of one overlay layer
// assumes frame, fetch and pixel strobes come from logic on pclk
//
// How it works
// - row pitch bytes added at row end
// - pixel pitch bytes added per pixel
// - fallback colour shown while channel disabled
// - key reference compared per colour component
// - mask selects compared key bits
// - matching only when key enable set
// - key applies to source or destination
// - stepped pixel is blended or negated
// - adder operand zero or stepped pixel
// - difference term zero or stepped pixel
// - difference times alpha or one minus
// - global alpha used only when enabled
// - local alpha used only when enabled
// - overlay colour from fallback or fetch
// - fetch only when dma layer set
// - narrow components widened, zero or msb fill
// - writing one starts channel
// - refresh applied at next frame start
// - head append pending until hardware done
// - stop takes effect at frame end
// - abort clears channel flags, fetch enable and pixel in flight at once
// - status shows on, refresh, append pending
//
// The APB interface to the registers was left to the implementer.
`include "olb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module olb_overlay_layer #(
  parameter int COMP_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  input  wire logic [31:0] layer_base_addr,
  input  wire logic        fetch_step,
  input  wire logic        fetch_row_last,
  input  wire logic        head_append_done,
  input  wire logic        pix_in_valid,
  input  wire logic [23:0] ovl_rgb,
  input  wire logic [7:0]  ovl_alpha,
  input  wire logic [3:0]  comp_bits,
  input  wire logic [23:0] dst_rgb,
  output logic [31:0]      fetch_addr,
  output logic             fetch_en,
  output logic [23:0]      pix_out,
  output logic             pix_out_valid,
  output logic             channel_active_flag,
  output logic             attribute_refresh_pending,
  output logic             head_append_pending,
  output logic             attr_apply,
  output logic             channel_abort_pulse
);

  olb_pkg::olb_state_t st_ff;
  olb_pkg::olb_state_t nxt_st;

  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // widen a right-aligned component of nb bits to 8 bits
  function automatic logic [7:0] widen(input logic [7:0] c,
                                       input logic [3:0] nb,
                                       input logic       fill);
    logic [7:0] r;
    logic [3:0] sh;
    r  = c;
    sh = 4'h0;
    if (nb != 4'h0 && nb < 4'h8) begin
      sh = 4'h8 - nb;
      r  = c << sh;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(sh) && fill) begin
          r[i] = r[7];
        end
      end
    end
    return r;
  endfunction

  // 8x8 product scaled back to 8 bits
  function automatic logic [7:0] scale(input logic [7:0] v,
                                       input logic [7:0] a);
    logic [15:0] p;
    p = v * a;
    return p[15:8];
  endfunction

  // apb phases: answer one cycle into the access phase
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd;
  // pixel path temporaries
  logic [23:0] ovl_full;
  logic [23:0] ovl_col;
  logic [23:0] keyed;
  logic [23:0] blended;
  logic [23:0] result;
  logic [7:0]  alpha;
  logic [7:0]  alpha_sel;
  logic [7:0]  o_c;
  logic [7:0]  d_c;
  logic [7:0]  s_c;
  logic [15:0] base_sum;
  logic [9:0]  total;
  logic        key_match;
  logic        show_dst;
  logic [23:0] bc;

  always_comb begin
    nxt_st    = st_ff;
    acc       = psel & penable;
    wr        = acc & st_ff.pready & pwrite;
    hit       = 1'b1;
    rd        = `OLB_RST_WORD;
    ovl_full  = 24'h000000;
    ovl_col   = 24'h000000;
    keyed     = 24'h000000;
    blended   = 24'h000000;
    result    = 24'h000000;
    alpha     = 8'hFF;
    alpha_sel = 8'hFF;
    o_c       = 8'h00;
    d_c       = 8'h00;
    s_c       = 8'h00;
    base_sum  = 16'h0000;
    total     = 10'h000;
    key_match = 1'b0;
    show_dst  = 1'b0;
    bc        = st_ff.blend_ctl;

    // read decode; write-only registers read as zero
    case (paddr)
      `OLB_ROW_PITCH_ADDR:   rd = st_ff.row_pitch;
      `OLB_PIXEL_PITCH_ADDR: rd = st_ff.pixel_pitch;
      `OLB_FALLBACK_ADDR:    rd = {8'h00, st_ff.fallback};
      `OLB_KEY_REF_ADDR:     rd = {8'h00, st_ff.key_ref};
      `OLB_KEY_MASK_ADDR:    rd = {8'h00, st_ff.key_mask};
      `OLB_BLEND_CTL_ADDR:   rd = {8'h00, st_ff.blend_ctl};
      `OLB_CHAN_START_ADDR:  rd = `OLB_RST_WORD;
      `OLB_CHAN_STOP_ADDR:   rd = `OLB_RST_WORD;
      `OLB_CHAN_STATUS_ADDR: rd = {29'h00000000, st_ff.append_pend,
                                   st_ff.refresh_pend, st_ff.chan_on};
      default:               hit = 1'b0;
    endcase

    // answer in the second access cycle, never back to back
    nxt_st.pready  = acc & ~st_ff.pready;
    nxt_st.pslverr = acc & ~st_ff.pready & ~hit;
    if (acc & ~st_ff.pready) begin
      nxt_st.prdata = pwrite ? `OLB_RST_WORD : rd;
    end

    // configuration writes, by byte lane
    if (wr) begin
      case (paddr)
        `OLB_ROW_PITCH_ADDR: begin
          nxt_st.row_pitch = merge(st_ff.row_pitch, pwdata, pstrb);
        end
        `OLB_PIXEL_PITCH_ADDR: begin
          nxt_st.pixel_pitch = merge(st_ff.pixel_pitch, pwdata, pstrb);
        end
        `OLB_FALLBACK_ADDR: begin
          nxt_st.fallback = 24'(merge({8'h00, st_ff.fallback}, pwdata,
                                      pstrb));
        end
        `OLB_KEY_REF_ADDR: begin
          nxt_st.key_ref = 24'(merge({8'h00, st_ff.key_ref}, pwdata,
                                     pstrb));
        end
        `OLB_KEY_MASK_ADDR: begin
          nxt_st.key_mask = 24'(merge({8'h00, st_ff.key_mask}, pwdata,
                                      pstrb));
        end
        `OLB_BLEND_CTL_ADDR: begin
          nxt_st.blend_ctl = 24'(merge({8'h00, st_ff.blend_ctl}, pwdata,
                                       pstrb) & `OLB_BLEND_CTL_MASK);
        end
        default: begin
        end
      endcase
    end

    // one-cycle events default low
    nxt_st.attr_apply = 1'b0;
    nxt_st.abort      = 1'b0;

    if (st_ff.stop_pend && frame_end) begin
      nxt_st.chan_on   = 1'b0;
      nxt_st.stop_pend = 1'b0;
    end
    if (st_ff.refresh_pend && frame_start) begin
      nxt_st.refresh_pend = 1'b0;
      nxt_st.attr_apply   = 1'b1;
    end
    if (head_append_done) begin
      nxt_st.append_pend = 1'b0;
    end

    // software requests come last so a set beats a same-cycle clear
    if (wr && paddr == `OLB_CHAN_START_ADDR) begin
      if (pwdata[`OLB_C_ON] && pstrb[0]) begin
        nxt_st.chan_on = 1'b1;
      end
      if (pwdata[`OLB_C_REFRESH] && pstrb[0]) begin
        nxt_st.refresh_pend = 1'b1;
      end
      if (pwdata[`OLB_C_APPEND] && pstrb[0]) begin
        nxt_st.append_pend = 1'b1;
      end
    end
    if (wr && paddr == `OLB_CHAN_STOP_ADDR) begin
      if (pwdata[`OLB_C_STOP] && pstrb[0] && st_ff.chan_on) begin
        nxt_st.stop_pend = 1'b1;
      end
      if (pwdata[`OLB_C_ABORT] && pstrb[1]) begin
        nxt_st.chan_on      = 1'b0;
        nxt_st.stop_pend    = 1'b0;
        nxt_st.refresh_pend = 1'b0;
        nxt_st.append_pend  = 1'b0;
        nxt_st.fetch_en     = 1'b0;
        nxt_st.abort        = 1'b1;
      end
    end

    // fetch runs only for a live dma layer
    nxt_st.fetch_en = nxt_st.chan_on & nxt_st.blend_ctl[`OLB_B_DMA_EN];

    // fetch address stepping, restarted each frame
    if (frame_start) begin
      nxt_st.fetch_addr = layer_base_addr;
    end else if (st_ff.fetch_en && fetch_step) begin
      nxt_st.fetch_addr = st_ff.fetch_addr + st_ff.pixel_pitch;
      if (fetch_row_last) begin
        nxt_st.fetch_addr = st_ff.fetch_addr + st_ff.pixel_pitch
                            + st_ff.row_pitch;
      end
    end

    // alpha sources; both on multiplies them
    if (bc[`OLB_B_GA_EN] && bc[`OLB_B_LA_EN]) begin
      alpha = scale(bc[`OLB_B_GA_LSB +: 8], ovl_alpha);
    end else if (bc[`OLB_B_GA_EN]) begin
      alpha = bc[`OLB_B_GA_LSB +: 8];
    end else if (bc[`OLB_B_LA_EN]) begin
      alpha = ovl_alpha;
    end
    alpha_sel = bc[`OLB_B_REV_ALPHA] ? (8'hFF - alpha) : alpha;

    for (int k = 0; k < 3; k++) begin
      ovl_full[k*8 +: 8] = widen(ovl_rgb[k*8 +: 8], comp_bits,
                                 bc[`OLB_B_MSB_FILL]);
    end
    if (st_ff.chan_on && bc[`OLB_B_OVL_EN] && bc[`OLB_B_DMA_EN]) begin
      ovl_col = ovl_full;
    end else begin
      ovl_col = st_ff.fallback;
    end

    for (int k = 0; k < 3; k++) begin
      o_c      = ovl_col[k*8 +: 8];
      d_c      = dst_rgb[k*8 +: 8];
      s_c      = bc[`OLB_B_USE_STEP] ? st_ff.stepped[k*8 +: 8] : 8'h00;
      // widen before multiplying so the product keeps all 16 bits
      base_sum = 16'(o_c) * 16'(alpha) + 16'(d_c) * 16'(8'hFF - alpha);
      total    = {2'b00, base_sum[15:8]} + {2'b00, scale(s_c, alpha_sel)};
      if (bc[`OLB_B_STEP_ADD]) begin
        total = total + {2'b00, st_ff.stepped[k*8 +: 8]};
      end
      // saturate rather than wrap to keep bright areas bright
      blended[k*8 +: 8] = (total > 10'h0FF) ? 8'hFF : total[7:0];
    end

    keyed     = bc[`OLB_B_KEY_DST] ? dst_rgb : ovl_col;
    key_match = ((keyed ^ st_ff.key_ref) & st_ff.key_mask) == 24'h000000;
    if (bc[`OLB_B_KEY_EN]) begin
      show_dst = bc[`OLB_B_KEY_DST] ? ~key_match : key_match;
    end
    result = show_dst ? dst_rgb : blended;

    nxt_st.pix_out_valid = pix_in_valid;
    if (pix_in_valid) begin
      nxt_st.pix_out = result;
      nxt_st.stepped = bc[`OLB_B_NEG_OUT] ? ~result : result;
    end
    // abort drops the pixel in flight
    if (nxt_st.abort) begin
      nxt_st.pix_out_valid = 1'b0;
      nxt_st.stepped       = `OLB_RST_COLOR;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.row_pitch     <= `OLB_RST_WORD;
      st_ff.pixel_pitch   <= `OLB_RST_WORD;
      st_ff.fallback      <= `OLB_RST_COLOR;
      st_ff.key_ref       <= `OLB_RST_COLOR;
      st_ff.key_mask      <= `OLB_RST_COLOR;
      st_ff.blend_ctl     <= `OLB_RST_BLEND;
      st_ff.chan_on       <= 1'b0;
      st_ff.stop_pend     <= 1'b0;
      st_ff.refresh_pend  <= 1'b0;
      st_ff.append_pend   <= 1'b0;
      st_ff.pready        <= 1'b0;
      st_ff.pslverr       <= 1'b0;
      st_ff.prdata        <= `OLB_RST_WORD;
      st_ff.fetch_addr    <= `OLB_RST_WORD;
      st_ff.fetch_en      <= 1'b0;
      st_ff.pix_out       <= `OLB_RST_COLOR;
      st_ff.pix_out_valid <= 1'b0;
      st_ff.stepped       <= `OLB_RST_COLOR;
      st_ff.attr_apply    <= 1'b0;
      st_ff.abort         <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata                    = st_ff.prdata;
  assign pready                    = st_ff.pready;
  assign pslverr                   = st_ff.pslverr;
  assign fetch_addr                = st_ff.fetch_addr;
  assign fetch_en                  = st_ff.fetch_en;
  assign pix_out                   = st_ff.pix_out;
  assign pix_out_valid             = st_ff.pix_out_valid;
  assign channel_active_flag       = st_ff.chan_on;
  assign attribute_refresh_pending = st_ff.refresh_pend;
  assign head_append_pending       = st_ff.append_pend;
  assign attr_apply                = st_ff.attr_apply;
  assign channel_abort_pulse       = st_ff.abort;

endmodule

`default_nettype wire

// File: shared/olb_map.svh
// register offsets, field positions, reset values of the overlay layer block
// assumes byte addresses on a 32-bit apb bus, one register per word
`ifndef OLB_MAP_SVH
`define OLB_MAP_SVH

// byte addresses of the registers
`define OLB_ROW_PITCH_ADDR      32'hF803813C
`define OLB_PIXEL_PITCH_ADDR    32'hF8038140
`define OLB_FALLBACK_ADDR       32'hF8038144
`define OLB_KEY_REF_ADDR        32'hF8038148
`define OLB_KEY_MASK_ADDR       32'hF803814C
`define OLB_BLEND_CTL_ADDR      32'hF8038150
`define OLB_CHAN_START_ADDR     32'hF8038280
`define OLB_CHAN_STOP_ADDR      32'hF8038284
`define OLB_CHAN_STATUS_ADDR    32'hF8038288

// blender control field positions
`define OLB_B_KEY_EN            0
`define OLB_B_NEG_OUT           1
`define OLB_B_STEP_ADD          2
`define OLB_B_USE_STEP          3
`define OLB_B_REV_ALPHA         4
`define OLB_B_GA_EN             5
`define OLB_B_LA_EN             6
`define OLB_B_OVL_EN            7
`define OLB_B_DMA_EN            8
`define OLB_B_MSB_FILL          9
`define OLB_B_KEY_DST           10
`define OLB_B_GA_LSB            16
`define OLB_BLEND_CTL_MASK      32'h00FF07FF

// channel start, stop and status field positions
`define OLB_C_ON                0
`define OLB_C_REFRESH           1
`define OLB_C_APPEND            2
`define OLB_C_STOP              0
`define OLB_C_ABORT             8

// reset values
`define OLB_RST_WORD            32'h00000000
`define OLB_RST_COLOR           24'h000000
`define OLB_RST_BLEND           24'h000000

`endif

// File: shared/olb_pkg.sv
// types of the overlay layer block
// assumes olb_map.svh for all numeric constants
package olb_pkg;

  // whole register and pipeline state of the block
  typedef struct packed {
    logic [31:0] row_pitch;
    logic [31:0] pixel_pitch;
    logic [23:0] fallback;
    logic [23:0] key_ref;
    logic [23:0] key_mask;
    logic [23:0] blend_ctl;
    logic        chan_on;
    logic        stop_pend;
    logic        refresh_pend;
    logic        append_pend;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] fetch_addr;
    logic        fetch_en;
    logic [23:0] pix_out;
    logic        pix_out_valid;
    logic [23:0] stepped;
    logic        attr_apply;
    logic        abort;
  } olb_state_t;

endpackage

// File: sim/olb_layer_chk_asserts.sv
// port checker of the overlay layer, bound into every instance
// assumes byte addresses of olb_map.svh and full-word writes
`include "olb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module olb_layer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        frame_start,
  input wire logic        frame_end,
  input wire logic        head_append_done,
  input wire logic        pix_in_valid,
  input wire logic        pix_out_valid,
  input wire logic        channel_active_flag,
  input wire logic        attribute_refresh_pending,
  input wire logic        head_append_pending,
  input wire logic        attr_apply,
  input wire logic        channel_abort_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completing writes, decoded the way the slave sees them
  logic acc, start_wr, abort_wr, stop_wr, armed_ff;
  assign acc      = psel && penable && pready && pwrite;
  assign start_wr = acc && paddr == `OLB_CHAN_START_ADDR && pstrb[0];
  assign stop_wr  = acc && paddr == `OLB_CHAN_STOP_ADDR;
  assign abort_wr = stop_wr && pwdata[8] && pstrb[1];

  // stop armed only while running, so a stray stop is not tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      armed_ff <= 1'b0;
    else if (stop_wr || frame_end)
      armed_ff <= stop_wr && pwdata[0] && channel_active_flag;
  end

  apb_one_wait_a: assert property (
    $rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  start_sets_on_a: assert property (
    start_wr && pwdata[0] |=> channel_active_flag)
    else $error("channel not on after start write");
  abort_clears_a: assert property (
    abort_wr |=> !channel_active_flag && !attribute_refresh_pending
      && !head_append_pending)
    else $error("flags not cleared by abort");
  stop_waits_a: assert property (
    channel_active_flag && !frame_end && !abort_wr |=> channel_active_flag)
    else $error("channel dropped before frame end");
  stop_at_end_a: assert property (
    armed_ff && frame_end && !start_wr |=> !channel_active_flag)
    else $error("channel still on after armed frame end");
  refresh_apply_a: assert property (
    attribute_refresh_pending && frame_start && !acc
      |=> attr_apply && !attribute_refresh_pending)
    else $error("refresh not applied at frame start");
  append_done_a: assert property (
    head_append_pending && head_append_done && !acc
      |=> !head_append_pending)
    else $error("append pending after done");
  abort_pulse_a: assert property (
    abort_wr |=> channel_abort_pulse)
    else $error("no abort pulse after abort write");
  pix_follow_a: assert property (
    pix_in_valid |=> pix_out_valid)
    else $error("pixel output missing");
endmodule

bind olb_overlay_layer olb_layer_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .frame_start(frame_start), .frame_end(frame_end),
  .head_append_done(head_append_done), .pix_in_valid(pix_in_valid),
  .pix_out_valid(pix_out_valid), .channel_active_flag(channel_active_flag),
  .attribute_refresh_pending(attribute_refresh_pending),
  .head_append_pending(head_append_pending), .attr_apply(attr_apply),
  .channel_abort_pulse(channel_abort_pulse)
);

`default_nettype wire

// File: sim/olb_frame_source.sv
// frame timing and descriptor queue side of the overlay layer
// assumes one pclk domain; a pulse on go asks for one frame
`timescale 1ns/1ps
`default_nettype none

module olb_frame_source #(
  parameter int NP = 4,
  parameter int NR = 2
) (
  input  wire logic pclk,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic head_append_pending,
  output logic      frame_start,
  output logic      frame_end,
  output logic      fetch_step,
  output logic      fetch_row_last,
  output logic      head_append_done
);
  // start, one step per pixel, last of row flagged, then end
  initial begin
    {frame_start, frame_end, fetch_step, fetch_row_last} = '0;
    forever begin
      @(posedge pclk);
      if (go) begin
        frame_start <= 1'b1;
        @(posedge pclk) frame_start <= 1'b0;
        @(posedge pclk);
        for (int k = 0; k < NP * NR; k++) begin
          fetch_step <= 1'b1;
          fetch_row_last <= k % NP == NP - 1;
          @(posedge pclk);
        end
        fetch_step <= 1'b0;
        fetch_row_last <= 1'b0;
        @(posedge pclk) frame_end <= 1'b1;
        @(posedge pclk) frame_end <= 1'b0;
      end
    end
  end

  // queue answers late or at once; slow keeps the pending flag visible
  initial begin
    head_append_done = 1'b0;
    forever begin
      @(posedge pclk);
      if (head_append_pending === 1'b1) begin
        repeat (slow ? 12 : 0) @(posedge pclk);
        head_append_done <= 1'b1;
        @(posedge pclk) head_append_done <= 1'b0;
        @(posedge pclk);
      end
    end
  end
endmodule

`default_nettype wire

// File: sim/olb_overlay_layer_bench.sv
// testbench of the overlay layer: register map, pixel mixing, channel
// assumes the frame source model and the bound port checker
`include "olb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module olb_overlay_layer_bench;
  localparam int NP = 4;
  localparam int NR = 2;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, fs, fe, fst, frl, had, apend, e;
  logic        go = 0, slow = 1, piv = 0;
  logic        fen, pov;
  logic [31:0] paddr = 0, pwdata = 0, prdata, base = 0, fa, r, d, pp, rp;
  logic [23:0] orgb = 0, drgb = 0, pout, fb, dr, kr, km;
  logic [7:0]  oal = 0, al, ga;
  logic [31:0] ra[6], rm[6];
  logic [23:0] fx[6] = '{24'h0, 24'h010000, 24'h000002, 24'h0, 24'h800000,
                         24'h0};
  int          mismatches = 0, n_compared = 0, cyc = 0;

  olb_overlay_layer i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(fs), .frame_end(fe), .layer_base_addr(base),
    .fetch_step(fst), .fetch_row_last(frl), .head_append_done(had),
    .pix_in_valid(piv), .ovl_rgb(orgb), .ovl_alpha(oal), .comp_bits(4'h0),
    .dst_rgb(drgb), .fetch_addr(fa), .fetch_en(fen), .pix_out(pout),
    .pix_out_valid(pov), .channel_active_flag(),
    .attribute_refresh_pending(), .head_append_pending(apend),
    .attr_apply(), .channel_abort_pulse()
  );

  olb_frame_source #(.NP(NP), .NR(NR)) i_src (
    .pclk(pclk), .go(go), .slow(slow), .head_append_pending(apend),
    .frame_start(fs), .frame_end(fe), .fetch_step(fst),
    .fetch_row_last(frl), .head_append_done(had)
  );

  always #2 pclk = ~pclk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, got);
    n_compared++;
    if (got !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, got);
    end
  endtask

  // one apb transfer; idle edge after it keeps drives single per step
  task automatic apb(input logic w, input logic [31:0] a, dd);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [31:0] a, x, input logic xe);
    apb(0, a, 32'h0);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  // one pixel in, result sampled one cycle later
  task automatic px(input logic [23:0] dd, input logic [7:0] a,
                    input logic [23:0] x);
    orgb <= 24'($urandom);
    drgb <= dd;
    oal <= a;
    piv <= 1;
    @(posedge pclk) piv <= 0;
    @(posedge pclk) chk("pix_out", {8'h0, x}, {8'h0, pout});
    chk("pix_out_valid", 32'h1, {31'h0, pov});
  endtask

  task automatic frame();
    int n;
    go <= 1;
    @(posedge pclk) go <= 0;
    n = 0;
    while (fe !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
  endtask

  function automatic logic [23:0] mix(input logic [23:0] o, t,
                                      input logic [7:0] a);
    for (int i = 0; i < 24; i += 8)
      mix[i+:8] = 8'((16'(o[i+:8]) * a + 16'(t[i+:8]) * (8'hFF - a)) >> 8);
  endfunction

  initial begin
    void'($urandom(10219));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    ra = '{`OLB_ROW_PITCH_ADDR, `OLB_PIXEL_PITCH_ADDR, `OLB_FALLBACK_ADDR,
           `OLB_KEY_REF_ADDR, `OLB_KEY_MASK_ADDR, `OLB_BLEND_CTL_ADDR};
    rm = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00FFFFFF, 32'h00FFFFFF,
           32'h00FFFFFF, `OLB_BLEND_CTL_MASK};
    // reset values, then random write and read back through writable-bit masks
    foreach (ra[i]) begin
      rd(ra[i], 32'h0, 1'b0);
      d = $urandom;
      apb(1, ra[i], d);
      rd(ra[i], d & rm[i], 1'b0);
    end
    rd(`OLB_CHAN_START_ADDR, 32'h0, 1'b0);
    rd(`OLB_CHAN_STOP_ADDR, 32'h0, 1'b0);
    apb(1, `OLB_CHAN_STATUS_ADDR, 32'hFFFFFFFF);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h0, 1'b0);
    rd(32'hF8038300, 32'h0, 1'b1);
    // channel off: fallback colour mixed with no, global, local alpha
    for (int k = 0; k < 3; k++) begin
      fb = 24'($urandom);
      dr = 24'($urandom);
      al = 8'($urandom);
      ga = 8'($urandom);
      apb(1, `OLB_FALLBACK_ADDR, {8'h0, fb});
      apb(1, `OLB_BLEND_CTL_ADDR, k == 0 ? 32'h0 :
          k == 1 ? {8'h0, ga, 16'h0020} : 32'h40);
      px(dr, al, mix(fb, dr, k == 0 ? 8'hFF : k == 1 ? ga : al));
    end
    // keying: match, masked miss, ignored bit, off, destination side
    kr = 24'($urandom);
    km = (24'($urandom) | 24'h010000) & ~24'h000002;
    apb(1, `OLB_KEY_REF_ADDR, {8'h0, kr});
    apb(1, `OLB_KEY_MASK_ADDR, {8'h0, km});
    for (int c = 0; c < 6; c++) begin
      dr = c < 4 ? 24'($urandom) : kr ^ (c == 5 ? 24'h010000 : 24'h0);
      apb(1, `OLB_FALLBACK_ADDR, {8'h0, kr ^ fx[c]});
      apb(1, `OLB_BLEND_CTL_ADDR, c == 3 ? 32'h0 : c < 4 ? 32'h1 : 32'h401);
      px(dr, 8'h0, (c == 0 || c == 2 || c == 5) ? dr :
         mix(kr ^ fx[c], dr, 8'hFF));
    end
    // one fetched frame with start, refresh and append requested
    base <= $urandom;
    pp = $urandom_range(64, 1);
    rp = $urandom;
    apb(1, `OLB_ROW_PITCH_ADDR, rp);
    apb(1, `OLB_PIXEL_PITCH_ADDR, pp);
    apb(1, `OLB_BLEND_CTL_ADDR, 32'h100);
    apb(1, `OLB_CHAN_START_ADDR, 32'h7);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h7, 1'b0);
    chk("fetch_en", 32'h1, {31'h0, fen});
    frame();
    chk("fetch_addr", base + NP * NR * pp + NR * rp, fa);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h1, 1'b0);
    // stop holds until the frame is over
    apb(1, `OLB_CHAN_STOP_ADDR, 32'h1);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h1, 1'b0);
    frame();
    rd(`OLB_CHAN_STATUS_ADDR, 32'h0, 1'b0);
    // prompt queue answer, then abort with a refresh pending
    slow <= 0;
    apb(1, `OLB_CHAN_START_ADDR, 32'h5);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h1, 1'b0);
    apb(1, `OLB_CHAN_START_ADDR, 32'h2);
    apb(1, `OLB_CHAN_STOP_ADDR, 32'h100);
    rd(`OLB_CHAN_STATUS_ADDR, 32'h0, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
